// ===== rtl/lcc_map.vh
`ifndef LCC_MAP_VH
`define LCC_MAP_VH
// Command opcodes
`define LCC_OP_CURSOR_FORM 8'h5d
`define LCC_OP_OVERLAY 8'h5b
`define LCC_OP_GLYPH_BASE 8'h5c
`define LCC_OP_HSCROLL 8'h5a
`define LCC_OP_CSR_WRITE 8'h46
`define LCC_OP_CSR_READ 8'h47
`define LCC_OP_PIX_DEPTH 8'h60
`define LCC_OP_DIR_MASK 8'hfc
`define LCC_OP_DIR_BASE 8'h4c
// Register offsets
`define LCC_REG_CSR_WIDTH 8'h15
`define LCC_REG_CSR_HEIGHT 8'h16
`define LCC_REG_STEP_DIR 8'h17
`define LCC_REG_OVERLAY 8'h18
// Field positions
`define LCC_SHAPE_SEL_BIT 7
`define LCC_THREE_LAYER_BIT 4
// Reset values
`define LCC_RST_BYTE 8'h00
`define LCC_RST_WORD 16'h0000
// Glyph bitmap geometry
`define LCC_BYTE_PIXELS 5'h08
// Decoder states
`define LCC_ST_IDLE 3'h0
`define LCC_ST_P1 3'h1
`define LCC_ST_P2 3'h2
`define LCC_ST_DONE 3'h3
`endif

// ===== rtl/lcc_cmd_decoder.v
`timescale 1ns/100ps
`default_nettype none
`include "lcc_map.vh"

// Summary of operation
// [R1] Command 5Dh takes two bytes: width to 15h, height to 16h.
// [R2] Second cursor-form byte bit 7 stored as shape select, 16h bit 7.
// [R3] Command 010011xx copies its low bits into step direction, 17h.
// [R4] Command 5Bh takes one byte, stored into overlay register 18h.
// [R5] Overlay byte bit 4 sets three-layer select, 18h bit 4.
// [R6] Overlay bits 3-2 store block 3 and block 1 display kind.
// [R7] Overlay bits 1-0 store the layer combining method.
// [R8] Command 5Ch takes low then high byte of glyph RAM base.
// [R9] Command 5Ah takes one byte; bits 2-0 are pixel shift.
// [R10] Command 46h loads 16-bit cursor address, low then high.
// [R11] After 47h, two parameter reads return cursor low then high.
// [R12] Command 60h takes one byte; bits 1-0 select pixel depth.
// [R13] Glyph origin top-left; adjacent bits are adjacent pixels.
// [R14] Cell width programmable up to 16; wide rows fetched as two bytes.
// [R15] Cell larger than bitmap is enlarged; zeros show as blank.
// [R16] No automatic gaps; software stores two bytes per row if needed.
// [R17] Select high write is command, low write parameter, high read read.
// [R18] Each memory access outside a second-parameter write cycle steps cursor address per direction field.
// [R19] Parameters counted in order; new command abandons sequence.
// [R20] Surplus parameters are ignored, registers unchanged.
module lcc_cmd_decoder #(
	parameter ADDR_W = 16,
	parameter CELL_W = 5,
	parameter [3:0] GLYPH_H = 4'h8
) (
	input wire clk,
	input wire rst_b,
	input wire bus_sel,
	input wire wr_stb,
	input wire rd_stb,
	input wire [7:0] wr_data,
	input wire mem_access,
	input wire [ADDR_W-1:0] step_amount,
	input wire [CELL_W-1:0] cell_width_setting,
	input wire [15:0] glyph_row_bits,
	input wire [3:0] glyph_col,
	input wire [3:0] glyph_line,
	output reg [7:0] rd_data_q,
	output reg [7:0] cursor_width_reg_q,
	output reg [7:0] cursor_height_shape_reg_q,
	output reg [7:0] cursor_step_direction_reg_q,
	output reg [7:0] layer_overlay_config_reg_q,
	output reg [ADDR_W-1:0] glyph_base_q,
	output reg [2:0] fine_hscroll_q,
	output reg [1:0] pixel_depth_q,
	output reg [ADDR_W-1:0] cursor_addr_q,
	output reg two_byte_rows_q,
	output reg glyph_pixel_q
);

	reg [7:0] cmd_q;
	reg [2:0] st_q;
	reg [7:0] low_q;
	reg rd_state_q;
	reg [1:0] rd_idx_q;

	wire cmd_wr;
	wire par_wr;
	wire par_rd;
	wire is_dir;
	wire wide_rows;
	wire in_cell;
	wire in_bitmap;
	reg glyph_pixel_d;

	// Pixel column lies below a width limit
	function col_below;
		input [3:0] col;
		input [4:0] lim;
		begin
			col_below = {1'b0, col} < lim;
		end
	endfunction

	// Bit 15 is the leftmost pixel; neighbours are adjacent bits
	function glyph_bit;
		input [15:0] row;
		input [3:0] col;
		begin
			glyph_bit = row[4'hf - col]; // [R13]
		end
	endfunction

	// Step cursor by amount in the chosen direction
	function [ADDR_W-1:0] csr_step;
		input [ADDR_W-1:0] addr;
		input [1:0] dir;
		input [ADDR_W-1:0] amt;
		begin
			case (dir)
				2'h0: csr_step = addr + amt;
				2'h1: csr_step = addr - amt;
				2'h2: csr_step = addr - amt;
				default: csr_step = addr + amt;
			endcase
		end
	endfunction

	// Bus decode by select line and strobe kind
	assign cmd_wr = bus_sel & wr_stb; // [R17]
	assign par_wr = ~bus_sel & wr_stb; // [R17]
	assign par_rd = bus_sel & rd_stb; // [R17]
	assign is_dir = (wr_data & `LCC_OP_DIR_MASK) == `LCC_OP_DIR_BASE; // [R3]

	// Parameter sequencer; a command restarts the count
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q <= `LCC_RST_BYTE;
			st_q <= `LCC_ST_IDLE;
			low_q <= `LCC_RST_BYTE;
		end else if (cmd_wr) begin
			cmd_q <= wr_data;
			st_q <= is_dir ? `LCC_ST_DONE : `LCC_ST_P1; // [R19]
		end else if (par_wr) begin
			case (st_q)
				`LCC_ST_P1: begin
					low_q <= wr_data;
					st_q <= `LCC_ST_P2; // [R19]
				end
				`LCC_ST_P2: st_q <= `LCC_ST_DONE; // [R20]
				default: st_q <= st_q; // [R20]
			endcase
		end
	end

	// Configuration register loads from parameter bytes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cursor_width_reg_q <= `LCC_RST_BYTE;
			cursor_height_shape_reg_q <= `LCC_RST_BYTE;
			cursor_step_direction_reg_q <= `LCC_RST_BYTE;
			layer_overlay_config_reg_q <= `LCC_RST_BYTE;
			glyph_base_q <= `LCC_RST_WORD;
			fine_hscroll_q <= 3'h0;
			pixel_depth_q <= 2'h0;
			cursor_addr_q <= `LCC_RST_WORD;
		end else begin
			if (cmd_wr && is_dir)
				cursor_step_direction_reg_q <= {6'h00, wr_data[1:0]}; // [R3]
			if (par_wr && st_q == `LCC_ST_P1) begin
				case (cmd_q)
					`LCC_OP_CURSOR_FORM:
						cursor_width_reg_q <= {4'h0, wr_data[3:0]}; // [R1]
					`LCC_OP_OVERLAY:
						// Bits 4, 3-2 and 1-0 stored; top bits kept zero
						layer_overlay_config_reg_q <= {3'h0, wr_data[4:0]}; // [R4] [R5] [R6] [R7]
					`LCC_OP_HSCROLL:
						fine_hscroll_q <= wr_data[2:0]; // [R9]
					`LCC_OP_PIX_DEPTH:
						pixel_depth_q <= wr_data[1:0]; // [R12]
					default: ;
				endcase
			end
			// Two-byte commands commit on the second byte
			if (par_wr && st_q == `LCC_ST_P2) begin
				case (cmd_q)
					`LCC_OP_CURSOR_FORM:
						cursor_height_shape_reg_q <=
						    {wr_data[`LCC_SHAPE_SEL_BIT], 3'h0, wr_data[3:0]}; // [R1] [R2]
					`LCC_OP_GLYPH_BASE:
						glyph_base_q <= {wr_data, low_q}; // [R8]
					`LCC_OP_CSR_WRITE:
						cursor_addr_q <= {wr_data, low_q}; // [R10]
					default: ;
				endcase
			end else if (mem_access) begin
				cursor_addr_q <= csr_step(cursor_addr_q,
				    cursor_step_direction_reg_q[1:0], step_amount); // [R18]
			end
		end
	end

	// Cursor readback, low byte then high
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_state_q <= 1'b0;
			rd_idx_q <= 2'h0;
			rd_data_q <= `LCC_RST_BYTE;
		end else if (cmd_wr) begin
			rd_state_q <= (wr_data == `LCC_OP_CSR_READ); // [R11]
			rd_idx_q <= 2'h0;
		end else if (par_rd && rd_state_q) begin
			case (rd_idx_q)
				2'h0: rd_data_q <= cursor_addr_q[7:0]; // [R11]
				2'h1: rd_data_q <= cursor_addr_q[15:8]; // [R11]
				default: rd_data_q <= `LCC_RST_BYTE; // [R20]
			endcase
			if (rd_idx_q != 2'h2)
				rd_idx_q <= rd_idx_q + 2'h1;
		end
	end

	// Cells wider than eight pixels need two fetch bytes per row
	assign wide_rows = cell_width_setting > `LCC_BYTE_PIXELS; // [R14]
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			two_byte_rows_q <= 1'b0;
		else
			two_byte_rows_q <= wide_rows; // [R14] [R16]
	end

	// Enlarged cell: anything outside the bitmap shows blank
	assign in_cell = col_below(glyph_col, cell_width_setting); // [R14]
	assign in_bitmap = (glyph_line < GLYPH_H) &&
	    (col_below(glyph_col, `LCC_BYTE_PIXELS) || wide_rows); // [R15]

	// Pixel pick; a narrow cell only reads the first byte
	always @* begin
		glyph_pixel_d = 1'b0;
		if (in_cell && in_bitmap)
			glyph_pixel_d = glyph_bit(glyph_row_bits, glyph_col); // [R13]
	end

	// Registered so the scan side sees a clean pixel
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			glyph_pixel_q <= 1'b0;
		else
			glyph_pixel_q <= glyph_pixel_d; // [R15]
	end

endmodule // lcc_cmd_decoder
`default_nettype wire

// ===== dv/lcc_host.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_host (
	input wire logic clk,
	output var logic bus_sel = 0,
	output var logic wr_stb = 0,
	output var logic rd_stb = 0,
	output var logic [7:0] wr_data = 0
);
	// One strobed byte, sel high write is command
	task xfer(input logic s, w, input logic [7:0] v);
		@(posedge clk) #2;
		bus_sel = s;
		wr_stb = w;
		rd_stb = !w;
		wr_data = v;
		@(posedge clk) #2;
		{wr_stb, rd_stb} = 0;
		wr_data = ~v; // Released bus keeps no stale byte
	endtask
endmodule // lcc_host
`default_nettype wire

// ===== dv/lcc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bus_sel,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data_q,
	input wire logic [7:0] cursor_width_reg_q,
	input wire logic [7:0] cursor_height_shape_reg_q,
	input wire logic [7:0] cursor_step_direction_reg_q,
	input wire logic [7:0] layer_overlay_config_reg_q,
	input wire logic [15:0] cursor_addr_q
);
	logic [7:0] c_q;
	logic [1:0] n_q;
	wire p = wr_stb && !bus_sel;
	wire r = rd_stb && bus_sel;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Last command and bytes since; saturates so surplus stays seen
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			c_q <= 8'h00;
			n_q <= 2'h0;
		end else if (wr_stb && bus_sel) begin
			c_q <= wr_data;
			n_q <= 2'h0;
		end else if ((p || r) && n_q != 2'h2) begin
			n_q <= n_q + 2'h1;
		end
	end
	chk_dir_copy: assert property (wr_stb && bus_sel &&
		wr_data[7:2] == 6'h13 |=> cursor_step_direction_reg_q[1:0] ==
		$past(wr_data[1:0])) else $error("direction not copied");
	chk_width_load: assert property (p && c_q == 8'h5d && n_q == 0
		|=> cursor_width_reg_q[3:0] == $past(wr_data[3:0]))
		else $error("width not loaded");
	chk_shape_bit: assert property (p && c_q == 8'h5d && n_q == 1
		|=> cursor_height_shape_reg_q[7] == $past(wr_data[7]))
		else $error("shape bit not loaded");
	chk_overlay_load: assert property (p && c_q == 8'h5b && n_q == 0
		|=> layer_overlay_config_reg_q[4:0] == $past(wr_data[4:0]))
		else $error("overlay not loaded");
	chk_cursor_high: assert property (p && c_q == 8'h46 && n_q == 1
		|=> cursor_addr_q[15:8] == $past(wr_data))
		else $error("cursor high byte not loaded");
	chk_read_low: assert property (r && c_q == 8'h47 && n_q == 0
		|=> rd_data_q == $past(cursor_addr_q[7:0]))
		else $error("cursor low byte not returned");
	chk_read_high: assert property (r && c_q == 8'h47 && n_q == 1
		|=> rd_data_q == $past(cursor_addr_q[15:8]))
		else $error("cursor high byte not returned");
	chk_surplus_kept: assert property (p && n_q == 2 |=>
		$stable(cursor_width_reg_q) && $stable(cursor_height_shape_reg_q)
		&& $stable(layer_overlay_config_reg_q)) else $error("surplus used");
endmodule // lcc_checker
`default_nettype wire

// ===== dv/lcc_cmd_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_cmd_decoder_tb;
	logic clk = 0;
	logic rst_b = 0;
	logic mem_access = 0;
	logic [15:0] step_amount = 16'h0001;
	logic [4:0] cell_width_setting = 5'h09;
	logic [15:0] glyph_row_bits = 0;
	logic [3:0] glyph_col = 0, glyph_line = 0;
	wire glyph_pixel_q;
	wire bus_sel, wr_stb, rd_stb;
	wire [7:0] wr_data;
	wire [77:0] o;
	logic [77:0] m = 0, prv = 0, q[$];
	logic [7:0] a, b;
	int n_fail = 0, compares = 0, seed = 79, i;
	always #12.5 clk = !clk;
	lcc_host host (.*);
	lcc_cmd_decoder dut (.*, .rd_data_q(o[77:70]),
		.cursor_width_reg_q(o[69:62]), .cursor_height_shape_reg_q(o[61:54]),
		.cursor_step_direction_reg_q(o[53:46]),
		.layer_overlay_config_reg_q(o[45:38]), .glyph_base_q(o[37:22]),
		.fine_hscroll_q(o[21:19]), .pixel_depth_q(o[18:17]),
		.cursor_addr_q(o[16:1]), .two_byte_rows_q(o[0]));
	task chk(input logic [77:0] s, e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR outputs exp %h got %h", e, s);
		end
	endtask
	task complete_run;
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Any output change retires the oldest note
	always @(posedge clk) begin
		prv <= o;
		if (rst_b && o !== prv) chk(o, q.size() ? q.pop_front() : ~o);
	end
	initial begin
		m[0] = 1;
		q.push_back(m);
		repeat (6) @(posedge clk);
		#2 rst_b = 1;
		a = $random(seed) | 1;
		b = a ^ 8'h80; // Nonzero and distinct so each note shows
		host.xfer(1, 1, 8'h5d);
		host.xfer(0, 1, a & 8'h0f);
		m[65:62] = a[3:0];
		q.push_back(m);
		host.xfer(0, 1, b & 8'h8f);
		m[61:54] = b & 8'h8f;
		q.push_back(m);
		host.xfer(0, 1, 8'hff);
		host.xfer(1, 1, 8'h5b);
		host.xfer(0, 1, b & 8'h1f);
		m[45:38] = b & 8'h1f;
		q.push_back(m);
		host.xfer(1, 1, 8'h5c);
		host.xfer(0, 1, a);
		host.xfer(0, 1, b);
		m[37:22] = {b, a};
		q.push_back(m);
		host.xfer(1, 1, 8'h5a);
		host.xfer(0, 1, a & 8'h07);
		m[21:19] = a[2:0];
		q.push_back(m);
		host.xfer(1, 1, 8'h60);
		host.xfer(0, 1, a & 8'h03);
		m[18:17] = a[1:0];
		q.push_back(m);
		// Half pair dropped by a fresh command
		host.xfer(1, 1, 8'h46);
		host.xfer(0, 1, 8'h55);
		host.xfer(1, 1, 8'h46);
		host.xfer(0, 1, a);
		host.xfer(0, 1, b);
		m[16:1] = {b, a};
		q.push_back(m);
		host.xfer(1, 1, 8'h47);
		host.xfer(1, 0, 8'h00);
		m[77:70] = a;
		q.push_back(m);
		host.xfer(1, 0, 8'h00);
		m[77:70] = b;
		q.push_back(m);
		// Each direction, then one access steps the cursor
		for (i = 0; i < 4; i++) begin
			host.xfer(1, 1, 8'(8'h4c + i));
			m[47:46] = 2'(i);
			if (i > 0) q.push_back(m);
			step_amount = 16'($random(seed) | 1);
			@(posedge clk) #2 mem_access = 1;
			@(posedge clk) #2 mem_access = 0;
			m[16:1] = (i == 1 || i == 2) ? m[16:1] - step_amount :
				m[16:1] + step_amount;
			q.push_back(m);
		end
		// Nine-pixel cell: bitmap columns, blank margin, blank row
		glyph_row_bits = {a, b};
		for (i = 0; i < 17; i++) begin
			glyph_col = 4'(i);
			glyph_line = (i == 16) ? 4'h8 : 4'h0;
			@(posedge clk) #2;
			chk(78'(glyph_pixel_q), 78'(i < 9 && glyph_row_bits[15 - (i % 16)]));
		end
		repeat (4) @(posedge clk);
		chk(78'(q.size()), 78'h0);
		complete_run;
	end
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
endmodule // lcc_cmd_decoder_tb
bind lcc_cmd_decoder lcc_checker u_chk (.*);
`default_nettype wire
